// ==== src/scs_clock_sync.sv ====
/*
 * System time-of-day keeper with soft synchronisation to a minute pulse or to
 * reference times written over APB, auto-adjust, time zone and summer time.
 * Assumes one 20 MHz clock, APB master on the same clock, asynchronous pins.
 */
// Behaviour
// - system time stamps every logged event
// - deviation measured, filtered, corrected gradually below 4 s, stepped at 4 s or more
// - small lead never steps time backwards
// - minute pulse edge aligns to nearest minute
// - pulse source is none or input 1-6
// - latest sync origin recorded per sync
// - origin falls back internal after 1.5 min
// - signed offset added to reference time
// - sync events counted 0 to 65535
// - raw deviation reported, clamped to 32767
// - filtered deviation reported, clamped to 125
// - 1 ms auto-adjust every programmed interval
// - interval and drift sign learned, writable
// - zone offset in hundredths of hour
// - summer time adds one hour when enabled
// - summer window last Sundays March, October
module scs_clock_sync
   import scs_pkg::*;
#(
   parameter int unsigned MS_CYCLES = SCS_MS_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [5:0]  di_pins,
   input  wire logic        stamp_req,
   output logic      [35:0] stamp_time,
   output logic             stamp_valid
);

   logic [15:0] div_r;
   logic [26:0] ms_r;
   logic [8:0]  doy_r;
   logic [2:0]  wd_r;
   logic        leap_r, dst_en_r, aa_sign_r;
   logic [2:0]  sel_r;
   logic signed [31:0] ofs_r, zone_r, pend_r, filt_r, raw_r;
   logic [19:0] aa_int_r, aa_cnt_r;
   logic [16:0] since_r;
   logic [15:0] count_r;
   logic [3:0]  origin_r;
   logic [5:0]  di_s, di_d_r;
   logic        tick, wr_acc, di_evt, ref_wr, sync_evt, big_dev, aa_fire, dst_on;
   int          ms_s, rem, base, ref_t, dev, dev_c, filt_nxt, loc, carry;
   int          mar_end, oct_end, mar_sun, oct_sun;
   // pins cross into the clock domain before any logic reads them
   scs_sync2 #(.W(6)) u_di_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .din   (di_pins),
      .dout  (di_s)
   );
   // write strobe at the access edge, sync requests from pin and bus
   assign wr_acc   = psel & penable & pready & pwrite & ~pslverr;
   assign ref_wr   = wr_acc & (paddr == SCS_OFS_SYNC_REF);
   assign di_evt   = (sel_r != 3'h0) & di_s[sel_r - 3'h1] & ~di_d_r[sel_r - 3'h1];
   assign sync_evt = di_evt | ref_wr;
   assign tick     = (div_r == 16'(MS_CYCLES - 1));
   // reference, deviation and filter arithmetic
   always_comb begin
      ms_s = int'({5'h00, ms_r});
      rem  = ms_s % SCS_MIN_MS;
      if (rem >= SCS_HALF_MIN_MS) begin
         base = ms_s - rem + SCS_MIN_MS;
      end else begin
         base = ms_s - rem;
      end
      if (!di_evt) begin
         base = int'({5'h00, pwdata[26:0]});
      end
      ref_t = base + ofs_r;
      if (ref_t < 0) begin
         ref_t = ref_t + SCS_DAY_MS;
      end else if (ref_t >= SCS_DAY_MS) begin
         ref_t = ref_t - SCS_DAY_MS;
      end
      dev = ms_s - ref_t;
      if (dev > SCS_HALF_DAY_MS) begin
         dev = dev - SCS_DAY_MS;
      end else if (dev < -SCS_HALF_DAY_MS) begin
         dev = dev + SCS_DAY_MS;
      end
      big_dev = (dev >= SCS_STEP_LIMIT_MS) || (dev <= -SCS_STEP_LIMIT_MS);
      dev_c = dev;
      if (dev_c > SCS_RAW_DEV_MAX) begin
         dev_c = SCS_RAW_DEV_MAX;
      end else if (dev_c < -SCS_RAW_DEV_MAX) begin
         dev_c = -SCS_RAW_DEV_MAX;
      end
      filt_nxt = filt_r + ((dev_c - filt_r) >>> SCS_FILT_SHIFT);
      if (filt_nxt > SCS_FILT_MAX) begin
         filt_nxt = SCS_FILT_MAX;
      end else if (filt_nxt < -SCS_FILT_MAX) begin
         filt_nxt = -SCS_FILT_MAX;
      end
   end
   // summer-time window and local time
   always_comb begin
      mar_end = SCS_MAR31_DOY + int'({31'h0, leap_r});
      oct_end = SCS_OCT31_DOY + int'({31'h0, leap_r});
      mar_sun = mar_end - ((int'({29'h0, wd_r}) + mar_end + SCS_WEEK_PAD
                - int'({23'h0, doy_r})) % 7);
      oct_sun = oct_end - ((int'({29'h0, wd_r}) + oct_end + SCS_WEEK_PAD
                - int'({23'h0, doy_r})) % 7);
      dst_on = dst_en_r
               && ((int'({23'h0, doy_r}) > mar_sun)
                   || ((int'({23'h0, doy_r}) == mar_sun) && (ms_s >= SCS_DST_START_MS)))
               && ((int'({23'h0, doy_r}) < oct_sun)
                   || ((int'({23'h0, doy_r}) == oct_sun) && (ms_s < SCS_DST_END_MS)));
      loc = ms_s + zone_r * SCS_ZONE_STEP_MS;
      if (dst_on) begin
         loc = loc + SCS_HOUR_MS;
      end
      carry = 0;
      if (loc < 0) begin
         loc   = loc + SCS_DAY_MS;
         carry = -1;
      end else if (loc >= SCS_DAY_MS) begin
         loc   = loc - SCS_DAY_MS;
         carry = 1;
      end
   end
   // millisecond divider and pin edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r  <= 16'h0000;
         di_d_r <= 6'h00;
      end else begin
         div_r  <= tick ? 16'h0000 : div_r + 16'h0001;
         di_d_r <= di_s;
      end
   end
   // time of day, calendar and pending soft correction
   always_ff @(posedge pclk or negedge presetn) begin
      int step;
      int nxt;
      int pb;
      if (!presetn) begin
         ms_r   <= 27'h0000000;
         doy_r  <= 9'h000;
         wd_r   <= 3'h0;
         leap_r <= 1'b0;
         pend_r <= 32'sh00000000;
      end else begin
         pb   = pend_r;
         step = 1;
         if (tick && pend_r > 0) begin
            step = 0;
            pb   = pend_r - 1;
         end else if (tick && pend_r < 0) begin
            step = 2;
            pb   = pend_r + 1;
         end
         if (aa_fire) begin
            pb = aa_sign_r ? pb - 1 : pb + 1;
         end
         if (wr_acc && paddr == SCS_OFS_TIME) begin
            ms_r <= (int'({5'h00, pwdata[26:0]}) < SCS_DAY_MS) ? pwdata[26:0] : 27'h0000000;
            pb   = 0;
         end else if (wr_acc && paddr == SCS_OFS_CAL) begin
            doy_r  <= pwdata[8:0];
            wd_r   <= pwdata[SCS_CAL_WD_LSB +: 3];
            leap_r <= pwdata[SCS_CAL_LEAP_BIT];
         end else if (sync_evt && big_dev) begin
            ms_r <= ref_t[26:0];
            pb   = 0;
         end else if (tick) begin
            nxt = ms_s + step;
            if (nxt >= SCS_DAY_MS) begin
               nxt   = nxt - SCS_DAY_MS;
               doy_r <= (int'({23'h0, doy_r}) >= SCS_YEAR_DAYS - 1 + int'({31'h0, leap_r}))
                        ? 9'h000 : doy_r + 9'h001;
               wd_r  <= (wd_r == 3'h6) ? 3'h0 : wd_r + 3'h1;
            end
            ms_r <= nxt[26:0];
         end
         if (sync_evt && !big_dev) begin
            pb = pb + filt_nxt;
         end
         pend_r <= pb;
      end
   end
   // deviation reports and filter state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raw_r  <= 32'sh00000000;
         filt_r <= 32'sh00000000;
      end else if (sync_evt) begin
         raw_r  <= dev_c;
         filt_r <= big_dev ? 32'sh00000000 : filt_nxt;
      end
   end
   // auto-adjust timer, learned and written interval and drift sign
   always_ff @(posedge pclk or negedge presetn) begin
      int nint;
      if (!presetn) begin
         aa_int_r  <= 20'h00000;
         aa_sign_r <= 1'b0;
         aa_cnt_r  <= 20'h00000;
         aa_fire   <= 1'b0;
      end else begin
         aa_fire <= 1'b0;
         if (tick && aa_int_r != 20'h00000) begin
            if (aa_cnt_r + 20'h00001 >= aa_int_r) begin
               aa_cnt_r <= 20'h00000;
               aa_fire  <= 1'b1;
            end else begin
               aa_cnt_r <= aa_cnt_r + 20'h00001;
            end
         end
         nint = int'({12'h000, aa_int_r});
         if (wr_acc && paddr == SCS_OFS_AUTOADJ) begin
            nint      = int'({12'h000, pwdata[19:0]});
            aa_sign_r <= pwdata[SCS_AA_SIGN_BIT];
            aa_cnt_r  <= 20'h00000;
         end else if (sync_evt && !big_dev && origin_r != SCS_SRC_INTERNAL && dev != 0) begin
            if (nint == 0) begin
               nint      = int'({15'h0000, since_r});
               aa_sign_r <= (dev < 0);
            end else if ((dev > 0) == !aa_sign_r) begin
               nint = nint - (nint >>> SCS_LEARN_SHIFT);
            end else begin
               nint = nint + (nint >>> SCS_LEARN_SHIFT);
            end
            if (nint < 1) begin
               nint = 1;
            end
         end
         if (nint > SCS_AA_MAX_MS) begin
            nint = SCS_AA_MAX_MS;
         end
         aa_int_r <= nint[19:0];
      end
   end
   // sync origin, event count and fall-back timeout
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_r  <= 16'h0000;
         origin_r <= SCS_SRC_INTERNAL;
         since_r  <= 17'h00000;
      end else if (sync_evt) begin
         count_r  <= count_r + 16'h0001;
         origin_r <= di_evt ? SCS_SRC_DI : pwdata[SCS_REF_SRC_LSB +: 4];
         since_r  <= 17'h00000;
      end else if (tick) begin
         if (int'({15'h0000, since_r}) >= SCS_TIMEOUT_MS - 1) begin
            origin_r <= SCS_SRC_INTERNAL;
         end else begin
            since_r <= since_r + 17'h00001;
         end
      end
   end
   // settings written by software; offset and zone clamped to their ranges, out-of-range pulse select taken as 0
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_r    <= 3'h0;
         dst_en_r <= 1'b0;
         ofs_r    <= 32'sh00000000;
         zone_r   <= 32'sh00000000;
      end else if (wr_acc) begin
         case (paddr)
            SCS_OFS_CTRL: begin
               sel_r    <= (int'({29'h0, pwdata[2:0]}) > SCS_SEL_MAX) ? 3'h0 : pwdata[2:0];
               dst_en_r <= pwdata[SCS_CTRL_DST_BIT];
            end
            SCS_OFS_SYNC_OFS: begin
               ofs_r <= ($signed(pwdata) > SCS_OFS_MAX_MS) ? SCS_OFS_MAX_MS :
                        ($signed(pwdata) < -SCS_OFS_MAX_MS) ? -SCS_OFS_MAX_MS : $signed(pwdata);
            end
            SCS_OFS_ZONE: begin
               zone_r <= ($signed(pwdata) > SCS_ZONE_MAX) ? SCS_ZONE_MAX :
                         ($signed(pwdata) < -SCS_ZONE_MAX) ? -SCS_ZONE_MAX : $signed(pwdata);
            end
            default: begin
            end
         endcase
      end
   end
   // time stamp for events and disturbance records
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stamp_time  <= 36'h000000000;
         stamp_valid <= 1'b0;
      end else begin
         stamp_valid <= stamp_req;
         if (stamp_req) begin
            stamp_time <= {doy_r, ms_r};
         end
      end
   end
   // APB slave: answer prepared in the setup cycle, one-cycle access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pready  <= 1'b1;
         pslverr <= (paddr[1:0] != 2'b00) || (paddr > SCS_OFS_LOCAL);
         case (paddr)
            SCS_OFS_CTRL:     prdata <= {28'h0000000, dst_en_r, sel_r};
            SCS_OFS_TIME:     prdata <= {5'h00, ms_r};
            SCS_OFS_CAL:      prdata <= {19'h00000, leap_r, wd_r, doy_r};
            SCS_OFS_SYNC_REF: prdata <= 32'h00000000;
            SCS_OFS_SYNC_OFS: prdata <= ofs_r;
            SCS_OFS_AUTOADJ:  prdata <= {aa_sign_r, 11'h000, aa_int_r};
            SCS_OFS_ZONE:     prdata <= zone_r;
            SCS_OFS_STATUS:   prdata <= {12'h000, origin_r, count_r};
            SCS_OFS_DEV:      prdata <= {filt_r[15:0], raw_r[15:0]};
            SCS_OFS_LOCAL:    prdata <= {2'b00, carry[1:0], 1'b0, loc[26:0]};
            default:          prdata <= 32'h00000000;
         endcase
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end
endmodule

// ==== src/scs_pkg.sv ====
/*
 * Shared constants of the system clock synchronisation unit: register map,
 * field positions, setting limits, time figures and sync-origin codes.
 * Assumes a single 20 MHz APB clock domain; all times are kept in milliseconds.
 */
package scs_pkg;

   // clock rate and millisecond tick
   localparam int unsigned SCS_CLK_PERIOD_NS = 50;
   localparam int unsigned SCS_MS_NS         = 1000000;
   localparam int unsigned SCS_MS_CYCLES     = SCS_MS_NS / SCS_CLK_PERIOD_NS;

   // time figures in milliseconds, step limit also given in seconds
   localparam int SCS_DAY_MS        = 86400000;
   localparam int SCS_HALF_DAY_MS   = SCS_DAY_MS / 2;
   localparam int SCS_MIN_MS        = 60000;
   localparam int SCS_HALF_MIN_MS   = SCS_MIN_MS / 2;
   localparam int SCS_HOUR_MS       = 3600000;
   localparam int SCS_STEP_LIMIT_S  = 4;
   localparam int SCS_STEP_LIMIT_MS = SCS_STEP_LIMIT_S * 1000;
   localparam int SCS_TIMEOUT_MS    = 90000;          // one and a half minutes
   localparam int SCS_ZONE_STEP_MS  = 36000;          // one hundredth of an hour
   localparam int SCS_DST_START_MS  = 3 * SCS_HOUR_MS;
   localparam int SCS_DST_END_MS    = 4 * SCS_HOUR_MS;

   // limits of settings and reports, filter and learning shifts
   localparam int SCS_OFS_MAX_MS    = 10000000;
   localparam int SCS_ZONE_MAX      = 1500;
   localparam int SCS_AA_MAX_MS     = 1000000;
   localparam int SCS_RAW_DEV_MAX   = 32767;
   localparam int SCS_FILT_MAX      = 125;
   localparam int SCS_FILT_SHIFT    = 2;
   localparam int SCS_LEARN_SHIFT   = 4;
   localparam int SCS_SEL_MAX       = 6;

   // calendar: zero-based day of year, weekday 0 is Sunday
   localparam int SCS_MAR31_DOY     = 89;
   localparam int SCS_OCT31_DOY     = 303;
   localparam int SCS_YEAR_DAYS     = 365;
   localparam int SCS_WEEK_PAD      = 371;            // whole weeks above any day of year

   // register byte offsets
   localparam logic [7:0] SCS_OFS_CTRL     = 8'h00;
   localparam logic [7:0] SCS_OFS_TIME     = 8'h04;
   localparam logic [7:0] SCS_OFS_CAL      = 8'h08;
   localparam logic [7:0] SCS_OFS_SYNC_REF = 8'h0C;
   localparam logic [7:0] SCS_OFS_SYNC_OFS = 8'h10;
   localparam logic [7:0] SCS_OFS_AUTOADJ  = 8'h14;
   localparam logic [7:0] SCS_OFS_ZONE     = 8'h18;
   localparam logic [7:0] SCS_OFS_STATUS   = 8'h1C;
   localparam logic [7:0] SCS_OFS_DEV      = 8'h20;
   localparam logic [7:0] SCS_OFS_LOCAL    = 8'h24;

   // field positions
   localparam int SCS_CTRL_DST_BIT   = 3;
   localparam int SCS_CAL_WD_LSB     = 9;
   localparam int SCS_CAL_LEAP_BIT   = 12;
   localparam int SCS_REF_SRC_LSB    = 27;
   localparam int SCS_AA_SIGN_BIT    = 31;
   localparam int SCS_STAT_SRC_LSB   = 16;
   localparam int SCS_DEV_FILT_LSB   = 16;
   localparam int SCS_LOCAL_CARRY_LSB = 28;

   // origin of the latest synchronisation
   localparam logic [3:0] SCS_SRC_INTERNAL   = 4'h0;
   localparam logic [3:0] SCS_SRC_DI         = 4'h1;
   localparam logic [3:0] SCS_SRC_SNTP       = 4'h2;
   localparam logic [3:0] SCS_SRC_SPABUS     = 4'h3;
   localparam logic [3:0] SCS_SRC_MODBUS     = 4'h4;
   localparam logic [3:0] SCS_SRC_MODBUS_TCP = 4'h5;
   localparam logic [3:0] SCS_SRC_PROFIBUS   = 4'h6;
   localparam logic [3:0] SCS_SRC_IEC101     = 4'h7;
   localparam logic [3:0] SCS_SRC_IEC103     = 4'h8;
   localparam logic [3:0] SCS_SRC_DNP3       = 4'h9;
   localparam logic [3:0] SCS_SRC_TIMECODE   = 4'hA;

endpackage

// ==== src/scs_sync2.sv ====
/*
 * Two flip-flop synchroniser for a group of level inputs.
 * Assumes the inputs are asynchronous to clk; only the second stage is read.
 */
module scs_sync2 #(
   parameter int W = 6
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   logic [W-1:0] meta_r;

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         dout   <= '0;
      end else begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end

endmodule

// ==== dv/scs_clock_sync_monitor.sv ====
/*
 * Port checker of the clock sync unit: bus handshake, refusals, stamps, report ranges.
 * Assumes a bind onto scs_clock_sync, one clock and an active-low reset.
 */
module scs_clock_sync_monitor
   import scs_pkg::*;
#(
   parameter int unsigned MS_CYCLES = SCS_MS_CYCLES
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic [7:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [5:0]  di_pins,
   input wire logic        stamp_req,
   input wire logic [35:0] stamp_time,
   input wire logic        stamp_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic rd_done;
   logic setup;
   logic bad_addr;
   // completed reads, setup cycles and refused addresses
   assign rd_done  = psel && penable && pready && !pwrite;
   assign setup    = psel && !penable;
   assign bad_addr = paddr[1:0] != 2'b00 || paddr > SCS_OFS_LOCAL;
   // one wait-free access cycle per setup
   property p_ready_one;
      setup |=> pready ##1 !pready;
   endproperty
   a_ready_one: assert property (p_ready_one) else $error("access cycle not single");
   property p_ready_only;
      pready |-> psel && penable;
   endproperty
   a_ready_only: assert property (p_ready_only) else $error("pready outside access");
   // refusals answer with an error and zero data
   property p_err_bad;
      setup && bad_addr |=> pslverr && prdata == 32'h0;
   endproperty
   a_err_bad: assert property (p_err_bad) else $error("bad address not refused");
   property p_err_good;
      setup && !bad_addr |=> !pslverr;
   endproperty
   a_err_good: assert property (p_err_good) else $error("good address refused");
   property p_sel_range;
      rd_done && paddr == SCS_OFS_CTRL |-> prdata[2:0] <= 3'h6;
   endproperty
   a_sel_range: assert property (p_sel_range) else $error("pulse select out of range");
   property p_dev_range;
      rd_done && paddr == SCS_OFS_DEV |-> $signed(prdata[31:16]) <= 125
         && $signed(prdata[31:16]) >= -125 && prdata[15:0] != 16'h8000;
   endproperty
   a_dev_range: assert property (p_dev_range) else $error("deviation out of range");
   property p_local_range;
      rd_done && paddr == SCS_OFS_LOCAL |-> prdata[29:28] != 2'b10
         && prdata[26:0] < 27'h5265C00;
   endproperty
   a_local_range: assert property (p_local_range) else $error("local time out of range");
   // stamp answered next cycle and held until the next request
   property p_stamp_ans;
      stamp_req |=> stamp_valid;
   endproperty
   a_stamp_ans: assert property (p_stamp_ans) else $error("stamp not answered");
   property p_stamp_quiet;
      !stamp_req |=> !stamp_valid && $stable(stamp_time);
   endproperty
   a_stamp_quiet: assert property (p_stamp_quiet) else $error("stamp changed unasked");
   property p_stamp_range;
      stamp_valid |-> stamp_time[26:0] < 27'h5265C00 && stamp_time[35:27] <= 9'h16D;
   endproperty
   a_stamp_range: assert property (p_stamp_range) else $error("stamp out of range");
endmodule

bind scs_clock_sync scs_clock_sync_monitor #(.MS_CYCLES(MS_CYCLES)) u_scs_mon (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .di_pins(di_pins), .stamp_req(stamp_req),
   .stamp_time(stamp_time), .stamp_valid(stamp_valid));

// ==== dv/scs_time_source.sv ====
/*
 * Minute-pulse source standing at the unit's digital inputs.
 * Assumes inputs idle low through pull-downs and pin numbers 1 to 6.
 */
module scs_time_source #(
   parameter int HOLD = 1000
) (
   input  wire logic       pclk,
   input  wire logic       fire,
   input  wire logic [2:0] pin,
   output logic      [5:0] di_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   int         cnt   = 0;
   logic [2:0] pin_r = 3'h1;
   // pulse held HOLD cycles, leading edge rising
   always @(posedge pclk) begin
      if (fire) begin
         pin_r <= pin;
         cnt   <= HOLD;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end
   end
   // one direct feed per input, others rest at the pulled-down level
   assign di_pins = (cnt != 0) ? (6'h01 << (pin_r - 3'h1)) : 6'h00;
endmodule

// ==== dv/tb.sv ====
/*
 * Self-checking bench of the clock sync unit: registers, syncs, pulses, zones, stamps.
 * Assumes the unit, its port checker and the minute-pulse source model.
 */
`define SCS_CHK(n, e, g) \
   begin \
      cmp_count++; \
      if ((g) !== (e)) begin \
         failures++; \
         $display("[FAIL] %s expected %h seen %h", n, e, g); \
      end \
   end
module tb
   import scs_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [31:0] e;
      logic [31:0] m;
      logic        er;
   } scs_exp_t;
   localparam int MSC = 20;
   logic        pclk      = 1'b0;
   logic        presetn   = 1'b0;
   logic [7:0]  paddr     = 8'h00;
   logic        psel      = 1'b0;
   logic        penable   = 1'b0;
   logic        pwrite    = 1'b0;
   logic [31:0] pwdata    = 32'h0;
   logic        stamp_req = 1'b0;
   logic        fire      = 1'b0;
   logic [2:0]  pin       = 3'h1;
   logic [31:0] lfsr      = 32'h22;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [5:0]  di_pins;
   logic [35:0] stamp_time;
   logic        stamp_valid;
   logic [31:0] rd;
   logic [31:0] t0;
   logic [8:0]  xd;
   int          failures  = 0;
   int          cmp_count = 0;
   int          z;
   scs_exp_t    x;
   scs_exp_t    aq[$];
   logic [8:0]  sq[$];

   scs_clock_sync #(.MS_CYCLES(MSC)) DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .di_pins(di_pins), .stamp_req(stamp_req),
      .stamp_time(stamp_time), .stamp_valid(stamp_valid));
   scs_time_source #(.HOLD(50 * MSC)) u_src (.pclk(pclk), .fire(fire), .pin(pin),
      .di_pins(di_pins));

   // bench clock
   initial begin
      forever #25 pclk = ~pclk;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // one apb transfer; its expected answer is noted first
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] e, input logic [31:0] m, input logic er);
      int n;
      n = 0;
      aq.push_back('{e, m, er});
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) failures++;
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 32'h0, 32'h0, 1'b0);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      bus(1'b0, a, 32'h0, e, m, 1'b0);
   endtask

   task automatic rng(input string n, input logic [31:0] v, input int lo, input int hi);
      `SCS_CHK(n, 1'b1, v >= lo && v <= hi)
   endtask

   task automatic pulse(input logic [2:0] p);
      pin  <= p;
      fire <= 1'b1;
      @(posedge pclk);
      fire <= 1'b0;
      repeat (10) @(posedge pclk);
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // answers compared with the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && aq.size() > 0) begin
         x = aq.pop_front();
         `SCS_CHK("prdata", x.e & x.m, prdata & x.m)
         `SCS_CHK("pslverr", x.er, pslverr)
      end
      if (stamp_valid === 1'b1 && sq.size() > 0) begin
         xd = sq.pop_front();
         `SCS_CHK("stamp day", xd, stamp_time[35:27])
      end
   end

   // hang guard
   initial begin
      repeat (30000) @(posedge pclk);
      failures++;
      close_out();
   end

   // main sequence
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(SCS_OFS_CTRL, 32'h0, '1);
      rdc(SCS_OFS_STATUS, 32'h0, '1);
      rdc(SCS_OFS_AUTOADJ, 32'h0, '1);
      rdc(SCS_OFS_SYNC_REF, 32'h0, '1);
      bus(1'b0, 8'h28, 32'h0, 32'h0, '1, 1'b1);
      bus(1'b1, 8'h06, '1, 32'h0, '1, 1'b1);
      for (int i = 0; i < 8; i++) begin
         lfsr = lfsr_next(lfsr);
         z = int'(lfsr[15:4]) - 2048;
         wr(SCS_OFS_CTRL, {28'h0, lfsr[3:0]});
         rdc(SCS_OFS_CTRL, {28'h0, lfsr[3], lfsr[2:0] > 3'h6 ? 3'h0 : lfsr[2:0]}, '1);
         wr(SCS_OFS_ZONE, z);
         rdc(SCS_OFS_ZONE, z > 1500 ? 1500 : (z < -1500 ? -1500 : z), '1);
      end
      wr(SCS_OFS_SYNC_OFS, 32'h1312D00);
      rdc(SCS_OFS_SYNC_OFS, 32'h989680, '1);
      for (int c = 2; c <= 10; c++) begin
         wr(SCS_OFS_SYNC_REF, {1'b0, 4'(c), 27'h186A0});
         rdc(SCS_OFS_STATUS, {12'h0, 4'(c), 16'(c - 1)}, '1);
      end
      wr(SCS_OFS_AUTOADJ, 32'h0);
      $display("test registers_and_origins done");
      wr(SCS_OFS_SYNC_OFS, 32'h1388);
      wr(SCS_OFS_TIME, 32'h3E8);
      wr(SCS_OFS_SYNC_REF, {1'b0, SCS_SRC_SNTP, 27'h186A0});
      rdc(SCS_OFS_DEV, 32'h8001, '1);
      rdc(SCS_OFS_TIME, 32'h0, 32'h0);
      rng("stepped time", rd, 105000, 105001);
      wr(SCS_OFS_SYNC_OFS, 32'h0);
      rdc(SCS_OFS_TIME, 32'h0, 32'h0);
      wr(SCS_OFS_SYNC_REF, {1'b0, SCS_SRC_SNTP, rd[26:0] - 27'h64});
      rdc(SCS_OFS_DEV, 32'h190000, 32'hFFFF0000);
      rdc(SCS_OFS_TIME, 32'h0, 32'h0);
      t0 = rd;
      repeat (200) @(posedge pclk);
      rdc(SCS_OFS_STATUS, {12'h0, SCS_SRC_SNTP, 16'hB}, '1);
      rdc(SCS_OFS_TIME, 32'h0, 32'h0);
      `SCS_CHK("lead freeze", 32'h0, rd - t0)
      $display("test step_and_soft done");
      for (int s = 0; s < 2; s++) begin
         wr(SCS_OFS_AUTOADJ, {s[0], 31'h5});
         wr(SCS_OFS_TIME, 32'h0);
         rdc(SCS_OFS_AUTOADJ, {s[0], 31'h5}, '1);
         t0 = rd;
         rdc(SCS_OFS_TIME, 32'h0, 32'h0);
         t0 = rd;
         repeat (2000) @(posedge pclk);
         rdc(SCS_OFS_TIME, 32'h0, 32'h0);
         rng("adjusted advance", rd - t0, s ? 119 : 78, s ? 122 : 82);
      end
      wr(SCS_OFS_AUTOADJ, 32'h0);
      wr(SCS_OFS_ZONE, 32'h96);
      wr(SCS_OFS_TIME, 32'h2255100);
      for (int k = 0; k < 3; k++) begin
         wr(SCS_OFS_CAL, k == 2 ? 32'hA : 32'h64);
         wr(SCS_OFS_CTRL, {28'h0, k != 0, 3'h0});
         rdc(SCS_OFS_LOCAL, 32'h0, 32'h30000000);
         t0 = rd;
         rdc(SCS_OFS_TIME, 32'h0, 32'h0);
         z = 5400000 + (k == 1 ? 3600000 : 0);
         rng("local bias", {5'h00, t0[26:0]} - rd, z - 1, z);
      end
      wr(SCS_OFS_ZONE, -1500);
      rdc(SCS_OFS_LOCAL, 32'h30000000, 32'h30000000);
      rdc(SCS_OFS_TIME, 32'h0, 32'h0);
      sq.push_back(9'hA);
      stamp_req <= 1'b1;
      @(posedge pclk);
      stamp_req <= 1'b0;
      repeat (2) @(posedge pclk);
      rng("stamp time", {5'h00, stamp_time[26:0]} - rd, 0, 1);
      $display("test zone_and_stamp done");
      wr(SCS_OFS_CTRL, 32'h2);
      pulse(3'h3);
      repeat (1000) @(posedge pclk);
      rdc(SCS_OFS_STATUS, {12'h0, SCS_SRC_SNTP, 16'hB}, '1);
      wr(SCS_OFS_TIME, 32'h38270);
      pulse(3'h2);
      rdc(SCS_OFS_TIME, 32'h0, 32'h0);
      rng("minute snap", rd, 240000, 240001);
      repeat (1000) @(posedge pclk);
      rdc(SCS_OFS_STATUS, {12'h0, SCS_SRC_DI, 16'hC}, '1);
      $display("test minute_pulse done");
      close_out();
   end
endmodule
